// ---- rtl/gain_ranging_control.sv ----
// Added by the designer: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps

module gain_ranging_control
(
	// Clock and reset
	input  wire logic                   i_clock,
	input  wire logic                   i_rst_n,
	// Encode clock and select pins, asynchronous
	input  wire logic                   i_encode,
	input  wire logic                   i_select_a,
	input  wire logic                   i_select_b,
	// Peak comparators, positive and negative, asynchronous
	input  wire logic [4:0]             i_peak_pos,
	input  wire logic [4:0]             i_peak_neg,
	// Converter result, same clock
	input  wire logic [10:0]            i_adc_data,
	// Analog control
	output logic [2:0]                  o_atten_step,
	output logic                        o_connect_a,
	output logic                        o_filter_clamp,
	// Sample output
	output logic [10:0]                 o_mantissa,
	output logic [2:0]                  o_exponent,
	output logic                        o_source_channel_indicator,
	output logic                        o_sample_valid,
	// Avalon-MM slave
	input  wire logic [3:0]             i_avs_address,
	input  wire logic                   i_avs_read,
	input  wire logic                   i_avs_write,
	input  wire logic [31:0]            i_avs_writedata,
	output logic [31:0]                 o_avs_readdata,
	output logic                        o_avs_waitrequest
);

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	logic [12:0] sync_meta;
	logic [12:0] sync_q;
	logic        encode_prev;

	// Each pin crosses two flops before use, so edges show about three
	// clocks late; encode periods well above eight clocks are assumed.
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			sync_meta   <= 13'h0000;
			sync_q      <= 13'h0000;
			encode_prev <= 1'b0;
		end
		else
		begin
			sync_meta   <= {i_peak_neg, i_peak_pos, i_select_b,
				i_select_a, i_encode};
			sync_q      <= sync_meta;
			encode_prev <= sync_q[0];
		end
	end

	wire logic       encode_s   = sync_q[0];
	wire logic       select_a_s = sync_q[1];
	wire logic       select_b_s = sync_q[2];
	wire logic [4:0] trip_now   = sync_q[7:3] | sync_q[12:8];
	wire logic       enc_rise   = encode_s & ~encode_prev;
	wire logic       enc_fall   = ~encode_s & encode_prev;

	// ****************************************************************
	// Mode selection
	// ****************************************************************
	gain_ranging_pkg::input_mode_t mode;
	gain_ranging_pkg::input_mode_t pin_mode;
	logic                          alt_phase;
	logic                          conv_from_a;

	// The pin pair is the enum code itself, so no decode table is needed.
	assign pin_mode = gain_ranging_pkg::input_mode_t'({select_a_s,
		select_b_s});

	// ****************************************************************
	// Register file
	// ****************************************************************
	logic [1:0] control;
	logic       hold_sel;
	logic       last_peak_over;

	// Forcing the last step overrides the peak decision for clip testing.
	// Hysteresis can be turned off to watch the raw threshold decision.
	wire logic force_max = control[gain_ranging_pkg::CTL_FORCE_BIT];
	wire logic hyst_on   = control[gain_ranging_pkg::CTL_HYST_BIT];

	// ****************************************************************
	// Peak latch and range decision
	// ****************************************************************
	logic [4:0] trip_hold;
	logic [2:0] gain;
	logic [2:0] next_gain;
	logic [2:0] wanted;
	logic [2:0] peak_level;

	// Thresholds step down 6 dB each from full scale; the position of the
	// highest tripped comparator is the number of 6 dB steps the peak sits above the
	// lowest one. One extra step gives the headroom.
	always_comb
	begin
		peak_level = 3'h0;
		for (int k = 0; k < gain_ranging_pkg::THRESH_N; k++)
		begin
			if (trip_hold[k])
				peak_level = 3'(k + 1);
		end
	end

	// Beyond the top threshold the step saturates at the last attenuator,
	// where the converter is left to clip.
	assign wanted = (peak_level >= gain_ranging_pkg::GAIN_MAX) ?
		gain_ranging_pkg::GAIN_MAX : peak_level;

	// Rising is immediate to avoid over-range; falling needs the peak at
	// least two steps below the current range so noise cannot make it chatter.
	always_comb
	begin
		if (force_max)
			next_gain = gain_ranging_pkg::GAIN_MAX;
		else if (wanted > gain)
			next_gain = wanted;
		else if (!hyst_on || wanted < 3'(gain - 3'h1))
			next_gain = wanted;
		else if (wanted < gain)
			next_gain = gain;
		else
			next_gain = gain;
	end

	// A comparator that trips on the clearing cycle is kept, so a peak that
	// coincides with the encode fall is not lost.
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			trip_hold <= 5'h00;
		else if (enc_fall)
			trip_hold <= trip_now;
		else
			trip_hold <= trip_hold | trip_now;
	end

	// ****************************************************************
	// Encode sequencing
	// ****************************************************************
	logic [2:0] pending_gain;
	logic       pending_a;
	logic       pending_valid;

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			mode           <= gain_ranging_pkg::SEL_A;
			alt_phase      <= 1'b0;
			gain           <= gain_ranging_pkg::GAIN_RESET;
			conv_from_a    <= 1'b1;
			o_atten_step   <= gain_ranging_pkg::GAIN_RESET;
			o_connect_a    <= 1'b1;
			o_filter_clamp <= 1'b1;
			hold_sel       <= 1'b0;
			last_peak_over <= 1'b0;
		end
		else
		begin
			if (pin_mode != gain_ranging_pkg::SEL_INVALID)
				mode <= pin_mode;
			hold_sel <= (pin_mode == gain_ranging_pkg::SEL_INVALID);
			if (enc_fall)
			begin
				// Decision made on the encode fall, half an encode period ahead of the next hold edge.
				gain         <= next_gain;
				o_atten_step <= next_gain;
				last_peak_over <= (peak_level > gain_ranging_pkg::GAIN_MAX -
					3'h1);
				// Other modes rewind the phase so alternation opens on A.
				unique case (mode)
					gain_ranging_pkg::SEL_ALT:
					begin
						conv_from_a <= ~alt_phase;
						alt_phase   <= ~alt_phase;
					end
					gain_ranging_pkg::SEL_A:
					begin
						conv_from_a <= 1'b1;
						alt_phase   <= 1'b0;
					end
					gain_ranging_pkg::SEL_B:
					begin
						conv_from_a <= 1'b0;
						alt_phase   <= 1'b0;
					end
					default:
						conv_from_a <= conv_from_a;
				endcase
			end
			o_connect_a    <= conv_from_a;
			// Clamp while encode is high, after the hold edge, so every
			// sample starts its track phase from the same filter voltage.
			o_filter_clamp <= encode_s;
		end
	end

	// ****************************************************************
	// Output word
	// ****************************************************************
	// A converted word appears on the falling edge after its hold edge;
	// the gain and source used for that sample are carried alongside it.
	// The first encode fall after reset always follows a detected rise, so it
	// already produces a sample.
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			pending_gain  <= gain_ranging_pkg::GAIN_RESET;
			pending_a     <= 1'b1;
			pending_valid <= 1'b0;
			o_mantissa    <= 11'h000;
			o_exponent    <= gain_ranging_pkg::GAIN_RESET;
			o_source_channel_indicator <= 1'b1;
			o_sample_valid <= 1'b0;
		end
		else
		begin
			if (enc_rise)
			begin
				pending_gain  <= gain;
				pending_a     <= conv_from_a;
				pending_valid <= 1'b1;
			end
			o_sample_valid <= enc_fall & pending_valid;
			if (enc_fall && pending_valid)
			begin
				o_mantissa <= i_adc_data;
				o_exponent <= pending_gain;
				o_source_channel_indicator <= pending_a;
			end
		end
	end

	// ****************************************************************
	// Avalon-MM slave, one wait cycle per access
	// ****************************************************************
	// Waitrequest comes from a flop: every access costs one wait cycle,
	// traded for a short path from the address decode to the bus.
	logic access_done;
	wire logic access_req = i_avs_read | i_avs_write;
	wire logic sel_ctl    = i_avs_address == gain_ranging_pkg::REG_CONTROL;
	wire logic sel_sts    = i_avs_address == gain_ranging_pkg::REG_STATUS;
	wire logic sel_smp    = i_avs_address == gain_ranging_pkg::REG_SAMPLE;
	wire logic [7:0]  status_word = {last_peak_over, hold_sel, mode,
		o_atten_step, conv_from_a};
	wire logic [14:0] sample_word = {o_source_channel_indicator,
		o_exponent, o_mantissa};
	wire logic [31:0] rd_mux = sel_ctl ? {30'h0, control} :
		sel_sts ? {24'h0, status_word} :
		sel_smp ? {17'h0, sample_word} : gain_ranging_pkg::UNMAPPED_READ;

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			control           <= gain_ranging_pkg::CONTROL_RESET;
			access_done       <= 1'b0;
			o_avs_readdata    <= 32'h0000_0000;
			o_avs_waitrequest <= 1'b1;
		end
		else
		begin
			access_done       <= access_req & ~access_done;
			o_avs_waitrequest <= ~(access_req & ~access_done);
			if (access_req && !access_done)
				o_avs_readdata <= rd_mux;
			// A write lands where the master sees waitrequest low,
			// the second edge of the access.
			if (i_avs_write && access_done && sel_ctl)
				control <= i_avs_writedata[1:0];
		end
	end

endmodule : gain_ranging_control

// ---- rtl/gain_ranging_pkg.sv ----
package gain_ranging_pkg;

	// ****************************************************************
	// Widths and register map
	// ****************************************************************
	localparam int MANTISSA_W = 11;
	localparam int EXPONENT_W = 3;
	localparam int THRESH_N   = 5;

	localparam logic [3:0] REG_CONTROL = 4'h0;
	localparam logic [3:0] REG_STATUS  = 4'h4;
	localparam logic [3:0] REG_SAMPLE  = 4'h8;

	localparam int CTL_FORCE_BIT = 0;
	localparam int CTL_HYST_BIT  = 1;
	localparam logic [1:0] CONTROL_RESET = 2'h2;

	localparam logic [2:0] GAIN_RESET = 3'h0;
	localparam logic [2:0] GAIN_MAX   = 3'h5;
	localparam int STEP_DB = 6;

	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0]
	{
		SEL_INVALID,
		SEL_B,
		SEL_A,
		SEL_ALT
	} input_mode_t;

	typedef struct packed
	{
		logic                  from_a;
		logic [EXPONENT_W-1:0] exponent;
		logic [MANTISSA_W-1:0] mantissa;
	} sample_word_t;

endpackage : gain_ranging_pkg

// ---- tb/fixed_point_receiver.sv ----
`timescale 1ns/1ps
module fixed_point_receiver
(
	// Clock, reset and sample strobe
	input  wire logic                           i_clock,
	input  wire logic                           i_rst_n,
	input  wire logic                           i_valid,
	// Floating-point word from the converter control
	input  wire gain_ranging_pkg::sample_word_t i_word,
	// Fixed-point result
	output logic [15:0]                         o_fixed
);
	// Mantissa goes to the top, then shifts right less for larger exponents.
	always_ff @(posedge i_clock or negedge i_rst_n)
		if (!i_rst_n)
			o_fixed <= 16'h0000;
		else if (i_valid)
			o_fixed <= 16'($signed({i_word.mantissa, 5'h00})
				>>> (3'h5 - i_word.exponent));
endmodule : fixed_point_receiver

// ---- tb/gain_ranging_control_sva.sv ----
`timescale 1ns/1ps
module gain_ranging_control_chk
(
	// Clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_rst_n,
	// Pins driven toward the block
	input  wire logic        i_encode,
	input  wire logic        i_select_a,
	input  wire logic        i_select_b,
	// Outputs of the block
	input  wire logic        o_connect_a,
	input  wire logic        o_filter_clamp,
	input  wire logic        o_source_channel_indicator,
	input  wire logic        o_sample_valid,
	input  wire logic [2:0]  o_atten_step,
	input  wire logic [2:0]  o_exponent,
	input  wire logic [10:0] o_mantissa
);
	logic [1:0] sel_q;
	logic [7:0] held;
	logic       last_ind;
	wire        ok = held >= 8'h28;

	// Mode checks wait for the selects to settle through two encode periods,
	// the time a new selection needs to reach the output word.
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			sel_q    <= 2'h2;
			held     <= 8'h00;
			last_ind <= 1'b1;
		end
		else
		begin
			sel_q    <= {i_select_a, i_select_b};
			held     <= (sel_q != {i_select_a, i_select_b}) ? 8'h00 :
				(held == 8'hFF) ? held : held + 8'h01;
			if (o_sample_valid)
				last_ind <= o_source_channel_indicator;
		end
	end

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	chk_valid_pulse: assert property (
		o_sample_valid |=> !o_sample_valid)
		else $error("valid longer than one cycle");
	chk_word_moves: assert property (
		$changed({o_source_channel_indicator, o_exponent, o_mantissa})
		|-> o_sample_valid)
		else $error("output word changed without valid");
	chk_atten_span: assert property (
		o_atten_step <= 3'h5)
		else $error("attenuator step out of range");
	chk_exp_range: assert property (
		o_exponent <= 3'h5)
		else $error("exponent out of range");
	chk_alt_swap: assert property (
		o_sample_valid && ok && sel_q == 2'h3
		|-> o_source_channel_indicator != last_ind)
		else $error("alternate mode did not swap input");
	chk_only_a: assert property (
		o_sample_valid && ok && sel_q == 2'h2
		|-> o_source_channel_indicator)
		else $error("indicator low in input A mode");
	chk_only_b: assert property (
		o_sample_valid && ok && sel_q == 2'h1
		|-> !o_source_channel_indicator)
		else $error("indicator high in input B mode");
	chk_route_a: assert property (
		ok && sel_q == 2'h2 |-> o_connect_a)
		else $error("input A not routed");
	chk_clamp_high: assert property (
		$rose(i_encode) |-> ##[1:5] o_filter_clamp)
		else $error("clamp did not follow encode");
	chk_valid_low: assert property (
		o_sample_valid |-> !i_encode)
		else $error("sample delivered while encode high");
endmodule : gain_ranging_control_chk

bind gain_ranging_control gain_ranging_control_chk u_chk
(
	.i_clock(i_clock), .i_rst_n(i_rst_n), .i_encode(i_encode),
	.i_select_a(i_select_a), .i_select_b(i_select_b),
	.o_connect_a(o_connect_a), .o_filter_clamp(o_filter_clamp),
	.o_source_channel_indicator(o_source_channel_indicator),
	.o_sample_valid(o_sample_valid), .o_atten_step(o_atten_step),
	.o_exponent(o_exponent), .o_mantissa(o_mantissa)
);

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
	logic        clk, rst_n, enc, sa, sb, rd, wr, vld, ind, wt, ca, cl;
	logic [4:0]  pp, pn;
	logic [10:0] adc, man;
	logic [2:0]  att, ex;
	logic [3:0]  adr;
	logic [31:0] wd, rdd, rdv;
	logic [15:0] fx;
	logic        prev;
	int          fail_count, tests_run, cyc;

	gain_ranging_control dut (.i_clock(clk), .i_rst_n(rst_n),
		.i_encode(enc), .i_select_a(sa), .i_select_b(sb), .i_peak_pos(pp),
		.i_peak_neg(pn), .i_adc_data(adc), .o_atten_step(att),
		.o_connect_a(ca), .o_filter_clamp(cl), .o_mantissa(man),
		.o_exponent(ex), .o_source_channel_indicator(ind),
		.o_sample_valid(vld), .i_avs_address(adr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdd),
		.o_avs_waitrequest(wt));
	fixed_point_receiver rx (.i_clock(clk), .i_rst_n(rst_n), .i_valid(vld),
		.i_word({ind, ex, man}), .o_fixed(fx));

	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		rd  <= !w;
		wr  <= w;
		adr <= a;
		wd  <= d;
		do @(posedge clk); while (wt !== 1'b0);
		rdv = rdd;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus

	// The decision is pipelined, so several encodes settle the output.
	task run(input int n, input logic [10:0] d);
		repeat (n)
		begin
			repeat (10) @(posedge clk);
			enc <= 1'b1;
			adc <= d;
			repeat (10) @(posedge clk);
			enc <= 1'b0;
		end
		repeat (8) @(posedge clk);
	endtask : run

	task report_and_stop;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : report_and_stop

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			fail_count++;
			report_and_stop();
		end
	end

	initial
	begin
		{rst_n, enc, sb, rd, wr, pp, pn, adc, adr, wd} = '0;
		sa = 1'b1;
		repeat (6) @(posedge clk);
		chk({wt, ind, ex, vld}, 32'h0000_0030);
		rst_n <= 1'b1;
		bus(1'b0, gain_ranging_pkg::REG_CONTROL, 32'h0);
		chk(rdv, 32'h0000_0002);
		bus(1'b1, 4'hC, 32'hFFFF_FFFF);
		bus(1'b0, 4'hC, 32'h0);
		chk(rdv, gain_ranging_pkg::UNMAPPED_READ);
		pp <= 5'h04;
		run(4, 11'h123);
		chk({ind, ex, att, man}, {1'b1, 3'h3, 3'h3, 11'h123});
		pp <= 5'h00;
		pn <= 5'h10;
		run(3, 11'h423);
		chk(ex, 32'h5);
		pn <= 5'h00;
		pp <= 5'h08;
		run(3, 11'h423);
		chk(ex, 32'h5);
		pp <= 5'h02;
		run(3, 11'h423);
		chk({ex, man}, {3'h2, 11'h423});
		chk(fx, 32'h0000_F08C);
		bus(1'b0, gain_ranging_pkg::REG_SAMPLE, 32'h0);
		chk(rdv, 32'h0000_5423);
		bus(1'b1, gain_ranging_pkg::REG_CONTROL, 32'h3);
		run(3, 11'h055);
		chk(att, 32'h5);
		bus(1'b0, gain_ranging_pkg::REG_STATUS, 32'h0);
		chk(rdv, 32'h0000_002B);
		bus(1'b1, gain_ranging_pkg::REG_CONTROL, 32'h2);
		{sa, sb} <= 2'h1;
		run(3, 11'h2AA);
		chk({ind, ca, man}, {2'h0, 11'h2AA});
		{sa, sb} <= 2'h0;
		run(3, 11'h155);
		chk({ind, ca}, 32'h0);
		{sa, sb} <= 2'h3;
		run(3, 11'h001);
		prev = ind;
		run(1, 11'h002);
		chk(ind, !prev);
		report_and_stop();
	end
endmodule : testbench
